//--- float_add_defines.svh
// register offsets, field positions, reset values and opcode for the float add unit
// assumes inclusion by bare name from any file that needs these constants
`ifndef FLOAT_ADD_DEFINES_SVH
`define FLOAT_ADD_DEFINES_SVH

// register byte offsets on the apb window
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_ACC_SEL     8'h08
`define OFF_ACC_HI      8'h0C
`define OFF_ACC_LO      8'h10

// control register fields
`define CTRL_DBL        0
`define CTRL_TRUNC      1
`define CTRL_UNF_IE     2
`define CTRL_OVF_IE     3
`define CTRL_UV_IE      4
`define CTRL_LATE       5
`define CTRL_WIDTH      6
`define CTRL_RESET      6'h20

// condition flag positions, also status bits 3:0
`define FLAG_C          0
`define FLAG_V          1
`define FLAG_Z          2
`define FLAG_N          3

// sticky trap bits and busy in the status register
`define STAT_TRAP_MZ    4
`define STAT_TRAP_OVF   5
`define STAT_TRAP_UNF   6
`define STAT_BUSY       7

// instruction fields
`define OPC_HI          15
`define OPC_LO          8
`define OPC_ADD         8'hF4
`define ACC_FIELD_HI    7
`define ACC_FIELD_LO    6

// floating word fields
`define FP_SIGN         63
`define FP_EXP_HI       62
`define FP_EXP_LO       55
`define FP_FRAC_HI      54

`endif

//--- float_add_pkg.sv
// types shared by the float add unit and its adder core
// assumes nothing beyond a systemverilog compiler
package float_add_pkg;

    // sequencer states, gray along idle, calc, commit
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_CALC   = 2'b01,
        ST_COMMIT = 2'b11
    } exec_state_t;

    // reason reported with a trap pulse
    typedef enum logic [1:0] {
        CAUSE_NONE       = 2'b00,
        CAUSE_MINUS_ZERO = 2'b01,
        CAUSE_OVERFLOW   = 2'b10,
        CAUSE_UNDERFLOW  = 2'b11
    } trap_cause_t;

endpackage : float_add_pkg

//--- float_add_core.sv
// aligning adder with normalise and round or chop, registered result
// assumes operands held stable by the caller while load is high
`timescale 1ns/1ns
`default_nettype none
`include "float_add_defines.svh"

module float_add_core import float_add_pkg::*; (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        load,
    input  wire logic [63:0] opa,
    input  wire logic [63:0] opb,
    input  wire logic        dbl,
    input  wire logic        trunc,
    output logic      [63:0] sum_q,
    output logic             ovf_q,
    output logic             unf_q
);

    // fraction as seen in the chosen precision, single drops the low word
    function automatic logic [54:0] frac_view(input logic [54:0] f, input logic d);
        frac_view = d ? f : {f[54:32], 32'h0000_0000};
    endfunction : frac_view

    // leading zero count of the raw sum
    function automatic logic [5:0] lead_zeros(input logic [58:0] v);
        logic [5:0] n;
        logic       found;
        n = 6'h00;
        found = 1'b0;
        for (int i = 58; i >= 0; i--) begin
            if (!found) begin
                if (v[i]) found = 1'b1;
                else n = n + 6'h01;
            end
        end
        return n;
    endfunction : lead_zeros

    // unpack, zero exponent reads as zero including minus zero
    wire [7:0]  ea     = opa[`FP_EXP_HI:`FP_EXP_LO];
    wire [7:0]  eb     = opb[`FP_EXP_HI:`FP_EXP_LO];
    wire [55:0] ma     = (ea == 8'h00) ? 56'h0 : {1'b1, frac_view(opa[`FP_FRAC_HI:0], dbl)};
    wire [55:0] mb     = (eb == 8'h00) ? 56'h0 : {1'b1, frac_view(opb[`FP_FRAC_HI:0], dbl)};
    wire        a_big  = {ea, ma} >= {eb, mb};           // larger magnitude wins the sign
    wire [7:0]  e_big  = a_big ? ea : eb;
    wire [7:0]  e_sml  = a_big ? eb : ea;
    wire [55:0] m_big  = a_big ? ma : mb;
    wire [55:0] m_sml  = a_big ? mb : ma;
    wire        s_big  = a_big ? opa[`FP_SIGN] : opb[`FP_SIGN];
    wire        sub_op = opa[`FP_SIGN] ^ opb[`FP_SIGN];
    wire [7:0]  diff   = e_big - e_sml;

    // align smaller operand, guard bit plus sticky keep the error bounded
    wire [115:0] shifted = {m_sml, 60'h0} >> diff;
    wire         sticky  = |shifted[57:0];
    wire [57:0]  m_aln   = {shifted[115:59], shifted[58] | sticky};
    wire [58:0]  m_ext   = {1'b0, m_big, 2'b00};
    wire [58:0]  raw     = sub_op ? (m_ext - {1'b0, m_aln}) : (m_ext + {1'b0, m_aln});
    wire         zero_w  = (raw == 59'h0);              // exact cancellation gives plus zero
    wire [5:0]   lz      = lead_zeros(raw);
    wire [58:0]  norm    = raw << lz;

    // half lsb added for rounding, nothing for chopping
    wire [59:0] rnd_inc = trunc ? 60'h0 : (dbl ? 60'h4 : 60'h4_0000_0000);
    wire [59:0] rounded = {1'b0, norm} + rnd_inc;
    wire        rcarry  = rounded[59];
    wire [58:0] fin     = rcarry ? rounded[59:1] : rounded[58:0];
    wire [9:0]  e_fin   = {2'b00, e_big} + 10'h001 - {4'h0, lz} + {9'h000, rcarry};
    wire        ovf_w   = !zero_w && ($signed(e_fin) > $signed(10'h0FF));
    wire        unf_w   = !zero_w && ($signed(e_fin) < $signed(10'h001));

    // wrapped exponent on range faults, fraction stays correct
    wire [63:0] res_w = zero_w ? 64'h0 : {s_big, e_fin[7:0], frac_view(fin[57:3], dbl)};

    // capture result when the sequencer asks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sum_q <= 64'h0;
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
        end else if (clk_en && load) begin
            sum_q <= res_w;
            ovf_q <= ovf_w;
            unf_q <= unf_w;
        end
    end

    // bits below the lsb that a cancelling add could lose
    wire [58:0] lost_mask = dbl ? 59'h7 : 59'h7_FFFF_FFFF;

    property p_ovf_exp_small;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && load && ovf_w) |=> (sum_q[`FP_EXP_HI:`FP_EXP_LO] < $past(e_big));
    endproperty
    a_ovf_exp_small: assert property (p_ovf_exp_small)
        else $error("trapped overflow exponent not too small");

    property p_unf_exp_large;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && load && unf_w && (e_fin != 10'h000))
            |=> (sum_q[`FP_EXP_HI:`FP_EXP_LO] > $past(e_big));
    endproperty
    a_unf_exp_large: assert property (p_unf_exp_large)
        else $error("trapped underflow exponent not too large");

    property p_cancel_exact;
        @(posedge clk) disable iff (!reset_n)
        (load && sub_op && (diff < 8'h02) && (lz > 6'h01) && !zero_w)
            |-> ((norm & lost_mask) == 59'h0);
    endproperty
    a_cancel_exact: assert property (p_cancel_exact)
        else $error("cancelling add lost bits");

endmodule : float_add_core
`default_nettype wire

//--- float_add_unit.sv
// float add unit: decode, accumulators, sequencing, flags, traps, apb slave
// assumes instruction issue and apb master synchronous to CLK
`timescale 1ns/1ns
`default_nettype none
`include "float_add_defines.svh"

// Summary of operation
// - sum goes back into selected accumulator
// - precision and round or chop from control
// - disabled underflow stores exact zero
// - late model: disabled overflow stores zero
// - carry clear, overflow flag, zero flag
// - negative flag when stored value below zero
// - minus zero source traps before add
// - enabled range fault stores result, traps
// - trapped exponent wraps, fraction correct
// - close cancelling adds are exact
// - chopping error at most one lsb
// - single rounding error half lsb
// - double rounding error nine sixteenths lsb
// - minus zero only from range faults
// - minus zero stored only when trapped or on early model disabled overflow
module float_add_unit import float_add_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    input  wire logic              CLK_EN,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              INSTR_VALID,
    input  wire logic [15:0]       INSTR,
    input  wire logic [63:0]       FLOAT_SOURCE_OPERAND,
    output logic                   INSTR_READY,
    output logic                   DONE,
    output logic                   TRAP,
    output logic      [1:0]        TRAP_CAUSE,
    output logic                   REJECT,
    output logic      [3:0]        COND_FLAGS
);

    localparam int ACC_COUNT = 4;                    // two bit accumulator field

    // true when a floating word has a zero exponent
    function automatic logic exp_zero(input logic [63:0] w);
        exp_zero = (w[`FP_EXP_HI:`FP_EXP_LO] == 8'h00);
    endfunction : exp_zero

    // state registers
    logic [63:0]            acc_q [ACC_COUNT];       // accumulators
    logic [`CTRL_WIDTH-1:0] ctrl_q;                  // live control bits
    logic [`CTRL_WIDTH-1:0] snap_q;                  // control seen by the running add
    logic [3:0]             flags_q;                 // n z v c
    logic                   trap_mz_q;               // sticky minus zero trap
    logic                   trap_ovf_q;              // sticky overflow trap
    logic                   trap_unf_q;              // sticky underflow trap
    logic [1:0]             acc_sel_q;               // accumulator shown on apb
    exec_state_t            state_q;                 // sequencer
    logic [63:0]            opa_q;                   // latched accumulator operand
    logic [63:0]            opb_q;                   // latched source operand
    logic [1:0]             dst_q;                   // destination accumulator
    logic [31:0]            prdata_q;                // read data captured in setup
    logic                   pslverr_q;               // unmapped address flag
    logic                   done_q;                  // completion pulse
    logic                   trap_q;                  // trap pulse
    trap_cause_t            cause_q;                 // trap reason
    logic                   reject_q;                // non-add pulse

    // core results
    logic [63:0]            core_sum;
    logic                   core_ovf;
    logic                   core_unf;

    // apb decode
    wire apb_setup  = PSEL && !PENABLE;
    wire apb_wr     = PSEL && PENABLE && PWRITE && CLK_EN;
    wire hit_ctrl   = (PADDR == ADDR_W'(`OFF_CTRL));
    wire hit_status = (PADDR == ADDR_W'(`OFF_STATUS));
    wire hit_sel    = (PADDR == ADDR_W'(`OFF_ACC_SEL));
    wire hit_hi     = (PADDR == ADDR_W'(`OFF_ACC_HI));
    wire hit_lo     = (PADDR == ADDR_W'(`OFF_ACC_LO));
    wire mapped     = hit_ctrl || hit_status || hit_sel || hit_hi || hit_lo;
    wire busy       = (state_q != ST_IDLE);

    // status word: traps, busy and flags, upper bits zero
    wire [31:0] status_rd = {24'h00_0000, busy, trap_unf_q, trap_ovf_q, trap_mz_q, flags_q};
    wire [63:0] acc_view  = acc_q[acc_sel_q];
    wire [31:0] rd_val    = hit_ctrl   ? {26'h000_0000, ctrl_q} :
                            hit_status ? status_rd :
                            hit_sel    ? {30'h0000_0000, acc_sel_q} :
                            hit_hi     ? acc_view[63:32] :
                            hit_lo     ? acc_view[31:0] : 32'h0000_0000;

    // write one to clear requests for sticky traps
    wire clr_mz  = apb_wr && hit_status && PWDATA[`STAT_TRAP_MZ];
    wire clr_ovf = apb_wr && hit_status && PWDATA[`STAT_TRAP_OVF];
    wire clr_unf = apb_wr && hit_status && PWDATA[`STAT_TRAP_UNF];

    // instruction decode
    wire       accept    = INSTR_VALID && INSTR_READY && CLK_EN;
    wire       is_add    = (INSTR[`OPC_HI:`OPC_LO] == `OPC_ADD);
    wire [1:0] acc_field = INSTR[`ACC_FIELD_HI:`ACC_FIELD_LO];
    wire       src_mz    = FLOAT_SOURCE_OPERAND[`FP_SIGN] && exp_zero(FLOAT_SOURCE_OPERAND);

    // minus zero source with its trap enabled stops before the add
    wire uv_trap = accept && is_add && ctrl_q[`CTRL_UV_IE] && src_mz;
    wire start   = accept && is_add && !uv_trap;
    wire commit  = CLK_EN && (state_q == ST_COMMIT);

    // disabled underflow, or disabled overflow on the late model, gives zero
    wire unf_zero = core_unf && !snap_q[`CTRL_UNF_IE];
    wire ovf_zero = core_ovf && !snap_q[`CTRL_OVF_IE] && snap_q[`CTRL_LATE];
    wire zero_sub = unf_zero || ovf_zero;

    // faulty result kept and trapped when the matching enable is set
    wire trap_unf = core_unf && snap_q[`CTRL_UNF_IE];
    wire trap_ovf = core_ovf && snap_q[`CTRL_OVF_IE];

    // early model keeps a disabled overflow result untrapped
    wire [63:0] store_val = zero_sub ? 64'h0 : core_sum;

    // negative and zero flags from the stored value, overflow from the core, carry clear
    wire [3:0] flags_new = {store_val[`FP_SIGN] && !exp_zero(store_val),
                            exp_zero(store_val), core_ovf, 1'b0};

    // handshake outputs
    assign INSTR_READY = (state_q == ST_IDLE);
    assign PREADY      = CLK_EN;
    assign PRDATA      = prdata_q;
    assign PSLVERR     = pslverr_q;
    assign DONE        = done_q;
    assign TRAP        = trap_q;
    assign TRAP_CAUSE  = cause_q;
    assign REJECT      = reject_q;
    assign COND_FLAGS  = flags_q;

    // adder core, precision and rounding mode from the snapshot
    float_add_core u_core (
        .clk     (CLK),
        .reset_n (RESET_N),
        .clk_en  (CLK_EN),
        .load    (state_q == ST_CALC),
        .opa     (opa_q),
        .opb     (opb_q),
        .dbl     (snap_q[`CTRL_DBL]),
        .trunc   (snap_q[`CTRL_TRUNC]),
        .sum_q   (core_sum),
        .ovf_q   (core_ovf),
        .unf_q   (core_unf)
    );

    // sequencer: idle, calc, commit
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
        end else if (CLK_EN) begin
            case (state_q)
                ST_IDLE:   if (start) state_q <= ST_CALC;   // wait for an add
                ST_CALC:   state_q <= ST_COMMIT;            // core captures
                ST_COMMIT: state_q <= ST_IDLE;              // write back
                default:   state_q <= ST_IDLE;              // recover
            endcase
        end
    end

    // operand and control snapshot at accept
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            opa_q  <= 64'h0;
            opb_q  <= 64'h0;
            dst_q  <= 2'h0;
            snap_q <= `CTRL_RESET;
        end else if (start) begin
            opa_q  <= acc_q[acc_field];
            opb_q  <= FLOAT_SOURCE_OPERAND;
            dst_q  <= acc_field;
            snap_q <= ctrl_q;
        end
    end

    // accumulators: commit wins over an apb write in the same cycle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < ACC_COUNT; i++) acc_q[i] <= 64'h0;
        end else if (commit) begin
            acc_q[dst_q] <= store_val;
        end else if (apb_wr && hit_hi) begin
            acc_q[acc_sel_q][63:32] <= PWDATA;
        end else if (apb_wr && hit_lo) begin
            acc_q[acc_sel_q][31:0] <= PWDATA;
        end
    end

    // condition flags update on every completed add
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) flags_q <= 4'h0;
        else if (commit) flags_q <= flags_new;
    end

    // sticky traps: a new event beats a clear in the same cycle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            trap_mz_q  <= 1'b0;
            trap_ovf_q <= 1'b0;
            trap_unf_q <= 1'b0;
        end else if (CLK_EN) begin
            trap_mz_q  <= uv_trap || (trap_mz_q && !clr_mz);
            trap_ovf_q <= (commit && trap_ovf) || (trap_ovf_q && !clr_ovf);
            trap_unf_q <= (commit && trap_unf) || (trap_unf_q && !clr_unf);
        end
    end

    // completion and trap pulses, one enabled cycle each
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            done_q   <= 1'b0;
            trap_q   <= 1'b0;
            cause_q  <= CAUSE_NONE;
            reject_q <= 1'b0;
        end else if (CLK_EN) begin
            done_q   <= commit;
            reject_q <= accept && !is_add;
            trap_q   <= uv_trap || (commit && (trap_ovf || trap_unf));
            if (uv_trap) cause_q <= CAUSE_MINUS_ZERO;
            else if (commit && trap_ovf) cause_q <= CAUSE_OVERFLOW;
            else if (commit && trap_unf) cause_q <= CAUSE_UNDERFLOW;
        end
    end

    // apb control and selector writes
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_q    <= `CTRL_RESET;
            acc_sel_q <= 2'h0;
        end else if (apb_wr) begin
            if (hit_ctrl) ctrl_q <= PWDATA[`CTRL_WIDTH-1:0];
            if (hit_sel) acc_sel_q <= PWDATA[1:0];
        end
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (CLK_EN && apb_setup) begin
            prdata_q  <= PWRITE ? 32'h0000_0000 : rd_val;
            pslverr_q <= !mapped;
        end
    end

    property p_sum_written;
        @(posedge CLK) disable iff (!RESET_N)
        commit |=> (acc_q[dst_q] == $past(store_val)) && done_q;
    endproperty
    a_sum_written: assert property (p_sum_written)
        else $error("sum not written to accumulator");

    property p_unf_zero;
        @(posedge CLK) disable iff (!RESET_N)
        (commit && core_unf && !snap_q[`CTRL_UNF_IE]) |=> (acc_q[dst_q] == 64'h0) && !trap_q;
    endproperty
    a_unf_zero: assert property (p_unf_zero)
        else $error("disabled underflow did not store zero");

    property p_ovf_zero;
        @(posedge CLK) disable iff (!RESET_N)
        (commit && core_ovf && !snap_q[`CTRL_OVF_IE] && snap_q[`CTRL_LATE])
            |=> (acc_q[dst_q] == 64'h0) && flags_q[`FLAG_V];
    endproperty
    a_ovf_zero: assert property (p_ovf_zero)
        else $error("disabled overflow on late model did not store zero");

    property p_flags_cz;
        @(posedge CLK) disable iff (!RESET_N)
        done_q |-> !COND_FLAGS[`FLAG_C] && (COND_FLAGS[`FLAG_Z] == exp_zero(acc_q[dst_q]));
    endproperty
    a_flags_cz: assert property (p_flags_cz)
        else $error("carry or zero flag wrong after add");

    property p_flag_n;
        @(posedge CLK) disable iff (!RESET_N)
        done_q |-> (COND_FLAGS[`FLAG_N] ==
                    (acc_q[dst_q][`FP_SIGN] && !exp_zero(acc_q[dst_q])));
    endproperty
    a_flag_n: assert property (p_flag_n)
        else $error("negative flag wrong after add");

    property p_mz_trap;
        @(posedge CLK) disable iff (!RESET_N)
        uv_trap |=> trap_q && (cause_q == CAUSE_MINUS_ZERO) && (state_q == ST_IDLE)
                    && trap_mz_q;
    endproperty
    a_mz_trap: assert property (p_mz_trap)
        else $error("minus zero source did not trap before add");

    property p_fault_trap;
        @(posedge CLK) disable iff (!RESET_N)
        (commit && (trap_ovf || trap_unf)) |=> trap_q && (acc_q[dst_q] == $past(core_sum));
    endproperty
    a_fault_trap: assert property (p_fault_trap)
        else $error("enabled range fault did not keep result and trap");

    property p_no_minus_zero;
        @(posedge CLK) disable iff (!RESET_N)
        (commit && !core_ovf && !core_unf) |=>
            !(acc_q[dst_q][`FP_SIGN] && exp_zero(acc_q[dst_q]));
    endproperty
    a_no_minus_zero: assert property (p_no_minus_zero)
        else $error("ordinary add produced minus zero");

    // a trapped minus zero source leaves its accumulator alone
    property p_mz_keep;
        @(posedge CLK) disable iff (!RESET_N)
        (uv_trap && !(apb_wr && (hit_hi || hit_lo)))
            |=> (acc_q[$past(acc_field)] == $past(acc_q[acc_field]));
    endproperty
    a_mz_keep: assert property (p_mz_keep)
        else $error("minus zero trap changed the accumulator");

    // overflow flag follows the fault, carry always clear
    property p_ovf_flag;
        @(posedge CLK) disable iff (!RESET_N)
        commit |=> (flags_q[`FLAG_V] == $past(core_ovf)) && !flags_q[`FLAG_C];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("overflow or carry flag wrong after add");

    // early model keeps a disabled overflow result, no trap
    property p_early_keep;
        @(posedge CLK) disable iff (!RESET_N)
        (commit && core_ovf && !snap_q[`CTRL_OVF_IE] && !snap_q[`CTRL_LATE])
            |=> (acc_q[dst_q] == $past(core_sum)) && !trap_q;
    endproperty
    a_early_keep: assert property (p_early_keep)
        else $error("early model disabled overflow result not kept");

    // a word that is not an add is refused without starting
    property p_reject;
        @(posedge CLK) disable iff (!RESET_N)
        (accept && !is_add) |=> REJECT && (state_q == ST_IDLE);
    endproperty
    a_reject: assert property (p_reject)
        else $error("non add instruction not rejected");

endmodule : float_add_unit
`default_nettype wire

//--- float_host_model.sv
// host side model that issues instructions and operands to the float add unit
// assumes the bench calls issue from one process at a time
`timescale 1ns/1ns
`default_nettype none

module float_host_model (
    input  wire logic        CLK,
    input  wire logic        INSTR_READY,
    output var  logic        INSTR_VALID,
    output var  logic [15:0] INSTR,
    output var  logic [63:0] FLOAT_SOURCE_OPERAND
);
    // idle values from time zero
    initial begin
        INSTR_VALID = 1'b0;
        INSTR = 16'h0000;
        FLOAT_SOURCE_OPERAND = 64'h0;
    end

    // offer one word, hold it until taken, then scramble the released lines
    task issue(input logic [15:0] ins, input logic [63:0] op);
        @(posedge CLK);
        INSTR_VALID <= 1'b1;
        INSTR <= ins;
        FLOAT_SOURCE_OPERAND <= op;
        do @(posedge CLK); while (INSTR_READY !== 1'b1);
        INSTR_VALID <= 1'b0;
        INSTR <= ~ins;
        FLOAT_SOURCE_OPERAND <= ~op;
    endtask : issue
endmodule : float_host_model

`default_nettype wire

//--- float_add_unit_bench.sv
// self-checking bench for the float add unit: apb setup, add issue, result readback
// assumes the host model drives the instruction port
`timescale 1ns/1ns
`default_nettype none
`include "float_add_defines.svh"
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module float_add_unit_bench;
    logic        CLK, RESET_N, PSEL, PENABLE, PWRITE, er;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic        PREADY, PSLVERR, INSTR_VALID, INSTR_READY, DONE, TRAP, REJECT;
    logic [15:0] INSTR;
    logic [63:0] FLOAT_SOURCE_OPERAND;
    logic [1:0]  TRAP_CAUSE;
    logic [3:0]  COND_FLAGS;
    int          n_fail, check_count, cyc;

    float_add_unit u_float_add_unit (.CLK(CLK), .RESET_N(RESET_N), .CLK_EN(1'b1),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .INSTR_VALID(INSTR_VALID),
        .INSTR(INSTR), .FLOAT_SOURCE_OPERAND(FLOAT_SOURCE_OPERAND),
        .INSTR_READY(INSTR_READY), .DONE(DONE), .TRAP(TRAP), .TRAP_CAUSE(TRAP_CAUSE),
        .REJECT(REJECT), .COND_FLAGS(COND_FLAGS));
    float_host_model u_float_host_model (.CLK(CLK), .INSTR_READY(INSTR_READY),
        .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .FLOAT_SOURCE_OPERAND(FLOAT_SOURCE_OPERAND));

    // 25 mhz clock
    always #20 CLK = ~CLK;

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            end_sim();
        end
    end

    // counts, verdict, stop
    task end_sim;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // one apb transfer: setup, access until pready, then release
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    // load control and accumulator, add b, check trap, flags and stored value
    task run_add(input logic [5:0] c, input logic [1:0] s, input logic [63:0] a, b, e,
                 input logic [3:0] f, input logic [1:0] t);
        logic dn, tr, rdy;
        int   i;
        apb(1'b1, `OFF_CTRL, {26'h0, c});
        apb(1'b1, `OFF_ACC_SEL, {30'h0, s});
        apb(1'b1, `OFF_ACC_HI, a[63:32]);
        apb(1'b1, `OFF_ACC_LO, a[31:0]);
        dn = 1'b0;
        tr = 1'b0;
        u_float_host_model.issue({8'hF4, s, 6'h05}, b);
        for (i = 0; i < 8 && !dn && !tr; i++) begin
            @(negedge CLK);
            if (i == 0) rdy = (INSTR_READY === 1'b1);
            dn = (DONE === 1'b1);
            tr = (TRAP === 1'b1);
        end
        `CHK("trap", t != 2'h0, tr)
        `CHK("ready", t == 2'h1, rdy)
        `CHK("done", t != 2'h1, dn)
        `CHK("latency", (t == 2'h1) ? 1 : 3, i)
        if (t != 2'h0) `CHK("cause", t, TRAP_CAUSE)
        `CHK("flags", f, COND_FLAGS)
        apb(1'b0, `OFF_ACC_HI, 32'h0);
        `CHK("acc_hi", e[63:32], rd)
        apb(1'b0, `OFF_ACC_LO, 32'h0);
        `CHK("acc_lo", e[31:0], rd)
    endtask : run_add

    // main sequence
    initial begin
        CLK = 1'b0;
        RESET_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        n_fail = 0;
        check_count = 0;
        cyc = 0;
        repeat (10) @(posedge CLK);
        RESET_N <= 1'b1;
        apb(1'b0, `OFF_CTRL, 32'h0);
        `CHK("ctrl_reset", 32'h20, rd)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        `CHK("unmapped_rd", 32'h0, rd)
        run_add(6'h20, 0, 64'h40800000<<32, 64'h40800000<<32, 64'h41000000<<32, 4'h0, 0);
        run_add(6'h20, 1, 64'h41000000<<32, 64'hC1000000<<32, 64'h0, 4'h4, 0);
        run_add(6'h20, 2, 64'h0, 64'hC0800000<<32, 64'hC0800000<<32, 4'h8, 0);
        run_add(6'h30, 3, 64'hC0800000<<32, 64'h1<<63, 64'hC0800000<<32, 4'h8, 1);
        run_add(6'h20, 0, 64'h00A00000<<32, 64'h80800000<<32, 64'h0, 4'h4, 0);
        run_add(6'h24, 1, 64'h00A00000<<32, 64'h80800000<<32, 64'h7F800000<<32, 4'h0, 3);
        run_add(6'h20, 2, 64'h7FC00000<<32, 64'h7FC00000<<32, 64'h0, 4'h6, 0);
        run_add(6'h28, 3, 64'h7FC00000<<32, 64'h7FC00000<<32, 64'h00400000<<32, 4'h6, 2);
        run_add(6'h00, 0, 64'h7FC00000<<32, 64'h7FC00000<<32, 64'h00400000<<32, 4'h6, 0);
        run_add(6'h20, 1, 64'h40800000<<32, 64'h34800000<<32, 64'h40800001<<32, 4'h0, 0);
        run_add(6'h22, 2, 64'h40800000<<32, 64'h34800000<<32, 64'h40800000<<32, 4'h0, 0);
        run_add(6'h21, 3, 64'h40800000<<32, 64'h24800000<<32, 64'h4080000000000001, 4'h0, 0);
        apb(1'b0, `OFF_STATUS, 32'h0);
        `CHK("status_sticky", 32'h70, rd)
        apb(1'b1, `OFF_STATUS, 32'h70);
        apb(1'b0, `OFF_STATUS, 32'h0);
        `CHK("status_clear", 32'h00, rd)
        u_float_host_model.issue(16'hF005, 64'h0);
        @(negedge CLK);
        `CHK("reject", 1'b1, REJECT)
        end_sim();
    end
endmodule

`default_nettype wire
